// File: bus_cycle_regs.svh
`ifndef BUS_CYCLE_REGS_SVH
`define BUS_CYCLE_REGS_SVH

// ----------------------------------------
// bus widths
// ----------------------------------------
`define ADDR_W       23
`define DATA_W       16
`define FC_W         3
`define BE_W         2
`define BE_UPPER     1
`define BE_LOWER     0

// ----------------------------------------
// levels and defaults
// ----------------------------------------
`define STROBE_ON    1'b0
`define STROBE_OFF   1'b1
`define DIR_READ     1'b1
`define DIR_WRITE    1'b0
`define FIFO_DEPTH   4
`define HALF_DIV     1
`define SYNC_STAGES  3
`endif

// File: bus_cycle_pkg.sv
`include "bus_cycle_regs.svh"
package bus_cycle_pkg;
   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed
   {
      logic               write;
      logic [`FC_W-1:0]   fc;
      logic [`ADDR_W-1:0] addr;
      logic [`DATA_W-1:0] data;
      logic [`BE_W-1:0]   byteEn;
   } req_t;

   typedef struct packed
   {
      logic               fault;
      logic [`DATA_W-1:0] data;
   } resp_t;

   typedef enum logic [3:0]
   {
      ST_IDLE, ST_S0, ST_S1, ST_S2, ST_S3, ST_S4, ST_SW, ST_S5, ST_S6, ST_S7
   } bus_state_t;
endpackage : bus_cycle_pkg

// File: req_fifo.sv
`timescale 1ns/1ps
module req_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
)
(
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             reset,
   // fill side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // drain side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   generate
      if (WIDTH < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      begin : g_chk
         $error("req_fifo: DEPTH must be a power of two >= 2");
      end
   endgenerate

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
   logic [CW-1:0]    count_q, count_d;
   logic             ready_q, ready_d;
   logic             push, pop;

   // ----------------------------------------
   // pointers and count
   // ----------------------------------------
   always_comb
   begin
      push    = inValid && ready_q;
      pop     = outReady && (count_q != '0);
      wrPtr_d = push ? PW'(wrPtr_q + 1'b1) : wrPtr_q;
      rdPtr_d = pop ? PW'(rdPtr_q + 1'b1) : rdPtr_q;
      count_d = count_q;
      if (push && !pop)
      begin
         count_d = CW'(count_q + 1'b1);
      end
      else if (pop && !push)
      begin
         count_d = CW'(count_q - 1'b1);
      end
      ready_d = (count_d != CW'(DEPTH));
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
         ready_q <= 1'b1;
      end
      else
      begin
         wrPtr_q <= wrPtr_d;
         rdPtr_q <= rdPtr_d;
         count_q <= count_d;
         ready_q <= ready_d;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (push)
      begin
         mem[wrPtr_q] <= inData;
      end
   end

   assign inReady  = ready_q;
   assign outValid = (count_q != '0);
   assign outData  = mem[rdPtr_q];
endmodule : req_fifo

// File: bus_cycle_master.sv
`timescale 1ns/1ps
`include "bus_cycle_regs.svh"
module bus_cycle_master
#(
   parameter int FIFO_DEPTH = `FIFO_DEPTH,
   parameter int HALF_DIV   = `HALF_DIV
)
(
   // clock and reset
   input  wire logic                     mclk,
   input  wire logic                     reset,
   // request side
   input  wire logic                     reqValid,
   output logic                          reqReady,
   input  wire bus_cycle_pkg::req_t      reqData,
   // response side
   output logic                          respValid,
   output bus_cycle_pkg::resp_t          respData,
   // bus clock and control
   output logic                          busClk,
   output logic [`FC_W-1:0]              fc,
   output logic                          readWrite,
   output logic                          addr_strobe_n,
   output logic                          upper_byte_strobe_n,
   output logic                          lower_byte_strobe_n,
   output logic                          single_byte_strobe_n,
   // address bus
   output logic [`ADDR_W-1:0]            addrOut,
   output logic                          addrOe,
   // data bus
   input  wire logic [`DATA_W-1:0]       dataIn,
   output logic [`DATA_W-1:0]            dataOut,
   output logic                          dataOe,
   // slave answers
   input  wire logic                     transfer_ack_n,
   input  wire logic                     bus_fault_n
);
   localparam int DW = (HALF_DIV > 1) ? $clog2(HALF_DIV) : 1;

   generate
      if (HALF_DIV < 1)
      begin : g_chk
         $error("bus_cycle_master: HALF_DIV must be >= 1");
      end
   endgenerate

   // ----------------------------------------
   // request fifo
   // ----------------------------------------
   bus_cycle_pkg::req_t fifoData;
   logic                fifoValid;
   logic                fifoReady;
   logic                popReq;

   req_fifo
   #(
      .WIDTH ($bits(bus_cycle_pkg::req_t)),
      .DEPTH (FIFO_DEPTH)
   )
   u_fifo
   (
      .mclk     (mclk),
      .reset    (reset),
      .inValid  (reqValid),
      .inReady  (fifoReady),
      .inData   (reqData),
      .outValid (fifoValid),
      .outReady (popReq),
      .outData  (fifoData)
   );

   // ----------------------------------------
   // half-state divider
   // ----------------------------------------
   logic [DW-1:0] div_q, div_d;
   logic          tick;

   always_comb
   begin
      tick  = (div_q == DW'(HALF_DIV - 1));
      div_d = tick ? '0 : DW'(div_q + 1'b1);
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         div_q <= '0;
      end
      else
      begin
         div_q <= div_d;
      end
   end

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   logic [`SYNC_STAGES-1:0] ackSync_q, ackSync_d, faultSync_q, faultSync_d;
   logic                    ackSeen_q, ackSeen_d, faultSeen_q, faultSeen_d;

   always_comb
   begin
      ackSync_d   = {ackSync_q[`SYNC_STAGES-2:0], ~transfer_ack_n};
      faultSync_d = {faultSync_q[`SYNC_STAGES-2:0], ~bus_fault_n};
      ackSeen_d   = ackSeen_q;
      faultSeen_d = faultSeen_q;
      if (ackSync_q[`SYNC_STAGES-1] == ackSync_q[`SYNC_STAGES-2])
      begin
         ackSeen_d = ackSync_q[`SYNC_STAGES-1];
      end
      if (faultSync_q[`SYNC_STAGES-1] == faultSync_q[`SYNC_STAGES-2])
      begin
         faultSeen_d = faultSync_q[`SYNC_STAGES-1];
      end
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         ackSync_q   <= '0;
         faultSync_q <= '0;
         ackSeen_q   <= 1'b0;
         faultSeen_q <= 1'b0;
      end
      else
      begin
         ackSync_q   <= ackSync_d;
         faultSync_q <= faultSync_d;
         ackSeen_q   <= ackSeen_d;
         faultSeen_q <= faultSeen_d;
      end
   end

   // ----------------------------------------
   // bus state machine
   // ----------------------------------------
   bus_cycle_pkg::bus_state_t state_q, state_d;
   bus_cycle_pkg::req_t       cur_q, cur_d;
   bus_cycle_pkg::resp_t      resp_q, resp_d;
   logic                      respValid_q, respValid_d;
   logic                      busClk_q, busClk_d;
   logic [`FC_W-1:0]          fc_q, fc_d;
   logic                      rw_q, rw_d;
   logic                      as_q, as_d;
   logic                      uds_q, uds_d;
   logic                      lds_q, lds_d;
   logic                      ds_q, ds_d;
   logic [`ADDR_W-1:0]        addr_q, addr_d;
   logic                      addrOe_q, addrOe_d;
   logic [`DATA_W-1:0]        dout_q, dout_d;
   logic                      dataOe_q, dataOe_d;
   logic                      fault_q, fault_d;

   function automatic logic strobeFor(input logic en);
      strobeFor = en ? `STROBE_ON : `STROBE_OFF;
   endfunction : strobeFor

   always_comb
   begin
      state_d     = state_q;
      cur_d       = cur_q;
      resp_d      = resp_q;
      respValid_d = 1'b0;
      busClk_d    = busClk_q;
      fc_d        = fc_q;
      rw_d        = rw_q;
      as_d        = as_q;
      uds_d       = uds_q;
      lds_d       = lds_q;
      ds_d        = ds_q;
      addr_d      = addr_q;
      addrOe_d    = addrOe_q;
      dout_d      = dout_q;
      dataOe_d    = dataOe_q;
      fault_d     = fault_q;
      popReq      = 1'b0;
      if (tick)
      begin
         busClk_d = ~busClk_q;
         case (state_q)
            bus_cycle_pkg::ST_IDLE:
            begin
               if (!busClk_q && fifoValid)
               begin
                  state_d = bus_cycle_pkg::ST_S0;
                  popReq  = 1'b1;
                  cur_d   = fifoData;
                  fc_d    = fifoData.fc;
                  rw_d    = `DIR_READ;
                  fault_d = 1'b0;
               end
            end
            bus_cycle_pkg::ST_S0:
            begin
               state_d  = bus_cycle_pkg::ST_S1;
               addr_d   = cur_q.addr;
               addrOe_d = 1'b1;
            end
            bus_cycle_pkg::ST_S1:
            begin
               state_d = bus_cycle_pkg::ST_S2;
               as_d    = `STROBE_ON;
               if (cur_q.write)
               begin
                  rw_d = `DIR_WRITE;
               end
               else
               begin
                  uds_d = strobeFor(cur_q.byteEn[`BE_UPPER]);
                  lds_d = strobeFor(cur_q.byteEn[`BE_LOWER]);
                  ds_d  = strobeFor(|cur_q.byteEn);
               end
            end
            bus_cycle_pkg::ST_S2:
            begin
               state_d = bus_cycle_pkg::ST_S3;
               if (cur_q.write)
               begin
                  dataOe_d = 1'b1;
                  dout_d   = cur_q.data;
               end
            end
            bus_cycle_pkg::ST_S3:
            begin
               state_d = bus_cycle_pkg::ST_S4;
               if (cur_q.write)
               begin
                  uds_d = strobeFor(cur_q.byteEn[`BE_UPPER]);
                  lds_d = strobeFor(cur_q.byteEn[`BE_LOWER]);
                  ds_d  = strobeFor(|cur_q.byteEn);
               end
            end
            bus_cycle_pkg::ST_S4:
            begin
               if (ackSeen_q || faultSeen_q)
               begin
                  state_d = bus_cycle_pkg::ST_S5;
                  fault_d = faultSeen_q;
               end
               else
               begin
                  state_d = bus_cycle_pkg::ST_SW;
               end
            end
            bus_cycle_pkg::ST_SW:
            begin
               state_d = bus_cycle_pkg::ST_S4;
            end
            bus_cycle_pkg::ST_S5:
            begin
               state_d = bus_cycle_pkg::ST_S6;
            end
            bus_cycle_pkg::ST_S6:
            begin
               state_d = bus_cycle_pkg::ST_S7;
               as_d    = `STROBE_OFF;
               uds_d   = `STROBE_OFF;
               lds_d   = `STROBE_OFF;
               ds_d    = `STROBE_OFF;
               fault_d = fault_q || faultSeen_q;
               if (!cur_q.write)
               begin
                  resp_d.data = dataIn;
               end
            end
            bus_cycle_pkg::ST_S7:
            begin
               addrOe_d     = 1'b0;
               dataOe_d     = 1'b0;
               rw_d         = `DIR_READ;
               respValid_d  = 1'b1;
               resp_d.fault = fault_q;
               state_d      = bus_cycle_pkg::ST_IDLE;
               if (fifoValid)
               begin
                  state_d = bus_cycle_pkg::ST_S0;
                  popReq  = 1'b1;
                  cur_d   = fifoData;
                  fc_d    = fifoData.fc;
                  fault_d = 1'b0;
               end
            end
            default:
            begin
               state_d = bus_cycle_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         state_q     <= bus_cycle_pkg::ST_IDLE;
         cur_q       <= '0;
         resp_q      <= '0;
         respValid_q <= 1'b0;
         busClk_q    <= 1'b0;
         fc_q        <= '0;
         rw_q        <= `DIR_READ;
         as_q        <= `STROBE_OFF;
         uds_q       <= `STROBE_OFF;
         lds_q       <= `STROBE_OFF;
         ds_q        <= `STROBE_OFF;
         addr_q      <= '0;
         addrOe_q    <= 1'b0;
         dout_q      <= '0;
         dataOe_q    <= 1'b0;
         fault_q     <= 1'b0;
      end
      else
      begin
         state_q     <= state_d;
         cur_q       <= cur_d;
         resp_q      <= resp_d;
         respValid_q <= respValid_d;
         busClk_q    <= busClk_d;
         fc_q        <= fc_d;
         rw_q        <= rw_d;
         as_q        <= as_d;
         uds_q       <= uds_d;
         lds_q       <= lds_d;
         ds_q        <= ds_d;
         addr_q      <= addr_d;
         addrOe_q    <= addrOe_d;
         dout_q      <= dout_d;
         dataOe_q    <= dataOe_d;
         fault_q     <= fault_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign reqReady             = fifoReady;
   assign respValid            = respValid_q;
   assign respData             = resp_q;
   assign busClk               = busClk_q;
   assign fc                   = fc_q;
   assign readWrite            = rw_q;
   assign addr_strobe_n        = as_q;
   assign upper_byte_strobe_n  = uds_q;
   assign lower_byte_strobe_n  = lds_q;
   assign single_byte_strobe_n = ds_q;
   assign addrOut              = addr_q;
   assign addrOe               = addrOe_q;
   assign dataOut              = dout_q;
   assign dataOe               = dataOe_q;
endmodule : bus_cycle_master

// File: bus_cycle_master_checker.sv
`timescale 1ns/1ps
`include "bus_cycle_regs.svh"
module bus_cycle_master_checker
#(
   parameter int HALF_DIV = 1
)
(
   // clock and reset
   input wire logic               mclk,
   input wire logic               reset,
   // bus side
   input wire logic               respValid,
   input wire logic               busClk,
   input wire logic [`FC_W-1:0]   fc,
   input wire logic               readWrite,
   input wire logic               addr_strobe_n,
   input wire logic               upper_byte_strobe_n,
   input wire logic               lower_byte_strobe_n,
   input wire logic               single_byte_strobe_n,
   input wire logic [`ADDR_W-1:0] addrOut,
   input wire logic               addrOe,
   input wire logic [`DATA_W-1:0] dataOut,
   input wire logic               dataOe
);
   // ----------------
   // strobe low time
   // ----------------
   int lowCnt_d;
   int lowCnt_q;
   always_comb lowCnt_d = addr_strobe_n ? 0 : lowCnt_q + 1;
   always_ff @(posedge mclk or posedge reset)
      if (reset)
         lowCnt_q <= 0;
      else
         lowCnt_q <= lowCnt_d;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   // ----------------
   // properties
   // ----------------
   a_addr_drive_s1: assert property ($rose(addrOe) |-> $fell(busClk) && readWrite && $stable(fc))
      else $error("address drive not at falling bus clock with read level");
   a_strobe_at_s2: assert property ($fell(addr_strobe_n) |->
      $rose(busClk) && (readWrite != (upper_byte_strobe_n & lower_byte_strobe_n)))
      else $error("strobe start wrong");
   a_wr_data_first: assert property ($fell(lower_byte_strobe_n) && !readWrite |->
      $rose(busClk) && dataOe && $past(dataOe))
      else $error("write strobe before data");
   a_cycle_length: assert property ($rose(addr_strobe_n) |->
      lowCnt_q >= 5 * HALF_DIV && (lowCnt_q - 5 * HALF_DIV) % (2 * HALF_DIV) == 0)
      else $error("strobe length not whole periods");
   a_addr_held: assert property (addrOe && $past(addrOe) |-> $stable(addrOut) && $stable(fc))
      else $error("address changed in cycle");
   a_wdata_held: assert property (dataOe && $past(dataOe) |-> $stable(dataOut) && !readWrite)
      else $error("write data changed in cycle");
   a_strobes_off_s7: assert property ($rose(addr_strobe_n) |-> $fell(busClk) && upper_byte_strobe_n
      && lower_byte_strobe_n && single_byte_strobe_n && $stable(readWrite) && $stable(addrOe))
      else $error("strobe end wrong");
   a_addr_release: assert property ($fell(addrOe) |-> $rose(busClk) && addr_strobe_n)
      else $error("address release wrong");
   a_wr_release: assert property ($fell(dataOe) |-> $rose(readWrite) && $fell(addrOe))
      else $error("write release wrong");
   a_resp_at_end: assert property (respValid |-> $fell(addrOe) && $rose(busClk))
      else $error("response not at cycle end");
endmodule : bus_cycle_master_checker

bind bus_cycle_master bus_cycle_master_checker #(.HALF_DIV(HALF_DIV)) bus_cycle_master_checker_i
(
   .mclk, .reset, .respValid, .busClk, .fc, .readWrite, .addr_strobe_n, .upper_byte_strobe_n,
   .lower_byte_strobe_n, .single_byte_strobe_n, .addrOut, .addrOe, .dataOut, .dataOe
);

// File: bus_slave_model.sv
`timescale 1ns/1ps
`include "bus_cycle_regs.svh"
module bus_slave_model
(
   // clock and reset
   input  wire logic               mclk,
   input  wire logic               reset,
   // bus from master
   input  wire logic [`ADDR_W-1:0] addrOut,
   input  wire logic [`DATA_W-1:0] dataOut,
   input  wire logic               readWrite,
   input  wire logic               addr_strobe_n,
   input  wire logic               upper_byte_strobe_n,
   input  wire logic               lower_byte_strobe_n,
   // answer delay
   input  wire logic [7:0]         waitCycles,
   // answers
   output logic [`DATA_W-1:0]      dataIn,
   output logic                    transfer_ack_n,
   output logic                    bus_fault_n
);
   logic [`DATA_W-1:0] mem [16];
   int                 cnt;
   // ----------------
   // answer logic
   // ----------------
   always @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
         cnt = 0;
         dataIn = 16'h0000;
         transfer_ack_n = 1'b1;
         bus_fault_n = 1'b1;
      end
      else
      begin
         #1;
         if (addr_strobe_n)
         begin
            cnt = 0;
            transfer_ack_n = 1'b1;
            bus_fault_n = 1'b1;
         end
         else
         begin
            cnt = cnt + 1;
            if (cnt >= waitCycles && !addrOut[22]) transfer_ack_n = 1'b0;
            if ((cnt >= waitCycles && addrOut[22]) || (cnt >= waitCycles + 5 && addrOut[21])) bus_fault_n = 1'b0;
            if (!readWrite && !upper_byte_strobe_n) mem[addrOut[3:0]][15:8] = dataOut[15:8];
            if (!readWrite && !lower_byte_strobe_n) mem[addrOut[3:0]][7:0] = dataOut[7:0];
         end
         dataIn = (!addr_strobe_n && readWrite) ? mem[addrOut[3:0]] : ~dataIn;
      end
   end
endmodule : bus_slave_model

// File: bus_cycle_master_tb.sv
`timescale 1ns/1ps
`include "bus_cycle_regs.svh"
module bus_cycle_master_tb;
   logic                 mclk, reset, reqValid, reqReady, respValid, busClk, readWrite;
   logic                 addr_strobe_n, upper_byte_strobe_n, lower_byte_strobe_n, single_byte_strobe_n;
   logic                 addrOe, dataOe, transfer_ack_n, bus_fault_n, strobePrev, fixedWait;
   bus_cycle_pkg::req_t  reqData, busR, r;
   bus_cycle_pkg::resp_t respData;
   logic [`FC_W-1:0]     fc;
   logic [`ADDR_W-1:0]   addrOut;
   logic [`DATA_W-1:0]   dataIn, dataOut;
   logic [7:0]           waitCycles;
   logic [15:0]          rnd;
   logic [15:0]          memM [16];
   logic [17:0]          expR;
   logic [17:0]          respQ [$];
   bus_cycle_pkg::req_t  busQ [$];
   int                   errors = 0, cmp_count = 0, cycles = 0, refusals = 0, lowLen = 0;
   localparam int        HALF = 4;
   bus_cycle_master #(.FIFO_DEPTH(4), .HALF_DIV(HALF)) bus_cycle_master_i
   (
      .mclk(mclk), .reset(reset), .reqValid(reqValid), .reqReady(reqReady), .reqData(reqData),
      .respValid(respValid), .respData(respData), .busClk(busClk), .fc(fc), .readWrite(readWrite),
      .addr_strobe_n(addr_strobe_n), .upper_byte_strobe_n(upper_byte_strobe_n),
      .lower_byte_strobe_n(lower_byte_strobe_n), .single_byte_strobe_n(single_byte_strobe_n),
      .addrOut(addrOut), .addrOe(addrOe), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
      .transfer_ack_n(transfer_ack_n), .bus_fault_n(bus_fault_n)
   );
   bus_slave_model bus_slave_model_i
   (
      .mclk(mclk), .reset(reset), .addrOut(addrOut), .dataOut(dataOut), .readWrite(readWrite),
      .addr_strobe_n(addr_strobe_n), .upper_byte_strobe_n(upper_byte_strobe_n),
      .lower_byte_strobe_n(lower_byte_strobe_n), .waitCycles(waitCycles), .dataIn(dataIn),
      .transfer_ack_n(transfer_ack_n), .bus_fault_n(bus_fault_n)
   );
   // ----------------
   // helpers
   // ----------------
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish
   task automatic push(input bus_cycle_pkg::req_t q);
      int n;
      n = 0;
      reqValid = 1'b1;
      reqData = q;
      @(posedge mclk);
      while (reqReady !== 1'b1 && n < 5000)
      begin
         n++;
         refusals++;
         @(posedge mclk);
      end
      busQ.push_back(q);
      if (q.write && q.byteEn[1]) memM[q.addr[3:0]][15:8] = q.data[15:8];
      if (q.write && q.byteEn[0]) memM[q.addr[3:0]][7:0] = q.data[7:0];
      respQ.push_back({!q.write, q.addr[22] | q.addr[21], memM[q.addr[3:0]]});
      #2;
   endtask : push
   task automatic run(input int n, input logic [7:0] wt, input logic [1:0] flt, input logic rndAll);
      waitCycles = wt;
      fixedWait = !rndAll;
      for (int i = 0; i < n; i++)
      begin
         rnd = lfsr(rnd);
         r.data = rnd;
         rnd = lfsr(rnd);
         r.addr = {flt, 5'h00, rnd};
         r.addr[3:0] = 4'(i % (n / 2));
         r.fc = rnd[6:4];
         r.byteEn = (rnd[9:8] == 2'h0) ? 2'h3 : rnd[9:8];
         r.write = (i < n / 2);
         if (rndAll)
         begin
            waitCycles = 8'(rnd[12:8]);
            r.write = rnd[13];
            r.addr[3:0] = rnd[3:0];
         end
         push(r);
      end
      reqValid = 1'b0;
      while (respQ.size() != 0) @(posedge mclk);
      #2;
   endtask : run
   // ----------------
   // monitors
   // ----------------
   always @(negedge mclk)
   begin
      if (!reset && respValid === 1'b1 && respQ.size() == 0) check("unexpected response", 1'b1, 1'b0);
      else if (!reset && respValid === 1'b1)
      begin
         expR = respQ.pop_front();
         check("fault flag", respData.fault, expR[16]);
         if (expR[17]) check("read data", respData.data, expR[15:0]);
      end
      if (!reset && addr_strobe_n === 1'b0 && strobePrev === 1'b1)
      begin
         busR = busQ.pop_front();
         check("address", addrOut, busR.addr);
         check("function code", fc, busR.fc);
         check("direction", readWrite, !busR.write);
         check("upper strobe", upper_byte_strobe_n, busR.write | !busR.byteEn[1]);
         check("lower strobe", lower_byte_strobe_n, busR.write | !busR.byteEn[0]);
         check("single strobe", single_byte_strobe_n, busR.write | !(|busR.byteEn));
      end
      if (!reset && addr_strobe_n === 1'b1 && strobePrev === 1'b0)
      begin
         check("direction held", readWrite, !busR.write);
         check("data drive", dataOe, busR.write);
         if (busR.write) check("write data", dataOut, busR.data);
         if (fixedWait && waitCycles <= 8'h04) check("zero wait length", lowLen, 5 * HALF);
         if (fixedWait && waitCycles > 8'h10) check("wait states added", lowLen > 5 * HALF, 1'b1);
         lowLen = 0;
      end
      if (addr_strobe_n === 1'b0) lowLen++;
      strobePrev = addr_strobe_n;
   end
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         $display("[ERR] run length expected done seen hang");
         tally_and_finish();
      end
   end
   // ----------------
   // stimulus
   // ----------------
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   initial
   begin
      reset = 1'b1;
      reqValid = 1'b0;
      reqData = '0;
      waitCycles = 8'h02;
      strobePrev = 1'b1;
      fixedWait = 1'b1;
      rnd = 16'hD46F;
      for (int i = 0; i < 16; i++) memM[i] = 16'h0000;
      repeat (6) @(posedge mclk);
      #2;
      reset = 1'b0;
      check("ready after reset", reqReady, 1'b1);
      check("strobe idle", addr_strobe_n, 1'b1);
      check("address drive idle", addrOe, 1'b0);
      check("data drive idle", dataOe, 1'b0);
      @(posedge mclk);
      #2;
      run(8, 8'h02, 2'h0, 1'b0);
      check("full fifo refused", refusals > 0, 1'b1);
      run(4, 8'h19, 2'h0, 1'b0);
      run(4, 8'h02, 2'h2, 1'b0);
      run(4, 8'h06, 2'h1, 1'b0);
      run(24, 8'h00, 2'h0, 1'b1);
      check("bus idle at end", addrOe, 1'b0);
      tally_and_finish();
   end
endmodule : bus_cycle_master_tb
